/* verilog/llfs_sequencer.sv */
`default_nettype none
// What this block does
// RULE_01 - lost-link flag after 25000 silent frame periods
// RULE_02 - sleep after lost link only with the low-power bit
// RULE_03 - motion bit zero: no reference run; one: reference if needed
// RULE_04 - autonomous motion needs lost link, and motion bit or target not 0x400
// RULE_05 - referenced, lost in operation: one absolute safe move
// RULE_06 - unreferenced: negative half-range move to stall, OTP params
// RULE_07 - clear position at stall; normal case adds 10-step confirm
// RULE_08 - then move to safe target, skipped for 0x400
// RULE_09 - use the RAM copy of the safe target
// RULE_10 - safe target goes to target position, absolute move
// RULE_11 - park in stop or sleep per low-power bit
// RULE_12 - the safe target is eleven bits wide
// RULE_13 - floating address pin acts as lost link, no sleep with bus
// RULE_14 - lost at power-on, motion bit zero: absolute safe move
// RULE_15 - power-on end-stop direction follows the invert bit
// RULE_16 - power-on second move: bit 10 with invert, OTP params
// RULE_17 - power-on case omits the second move for 0x400
// RULE_18 - ten command pointers
// RULE_19 - addressed identifiers carry the slave address in bits 2:0
// RULE_20 - general-purpose frames map to pointers 0000 and 0001
// RULE_21 - decode command codes 0x00-0x06, 0x0f and 0x11
// RULE_22 - master assigns the preparing-frame identifier first
// RULE_23 - any valid frame restarts the gap counter
module llfs_sequencer
    import llfs_pkg::*;
#(
    parameter int unsigned LOST_FRAMES = LOST_FRAME_COUNT
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // otp settings and straps
    input  wire llfs_otp_s        otp,
    input  wire logic             hardwired_address_pin_float,
    input  wire logic [2:0]       slave_address,
    // bus frame events
    input  wire logic             frame_tick,
    input  wire logic             frame_valid,
    input  wire logic [5:0]       frame_id,
    input  wire logic             cmd_valid,
    input  wire logic [6:0]       cmd_code,
    // identifier assignment
    input  wire logic             dynid_we,
    input  wire logic [3:0]       dynid_ptr,
    input  wire logic [5:0]       dynid_value,
    // safe target and referencing from the command side
    input  wire logic             safe_target_we,
    input  wire logic [10:0]      safe_target_wdata,
    input  wire logic             referenced_set,
    // motion controller feedback
    input  wire logic             move_done,
    input  wire logic             stall_reached,
    input  wire logic [15:0]      half_range,
    input  wire logic [15:0]      current_position,
    // register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [15:0]      reg_wdata,
    input  wire logic             reg_we,
    input  wire logic             reg_re,
    output logic      [15:0]      reg_rdata,
    // decoded frame and command
    output logic                  ptr_hit,
    output logic      [3:0]       command_pointer,
    output logic      [6:0]       cmd_decoded,
    // motion and power
    output llfs_move_s            move,
    output logic                  position_clear,
    output logic      [15:0]      target_position,
    output logic                  lost_link,
    output logic                  stop_state,
    output logic                  sleep_state
);

    // ==========================================
    // reset release
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire logic rst_n = rst_sync_q;

    // ==========================================
    // lost-link gap counter
    localparam logic [14:0] LOST_LAST = 15'(LOST_FRAMES - 1);
    logic [14:0] gap_q;
    logic        lost_q;
    logic        bus_seen_q;
    wire logic   gap_full = frame_tick && (gap_q == LOST_LAST);
    wire logic [14:0] gap_d =
        frame_valid ? CNT_RESET :                        // see RULE_23
        (frame_tick && !lost_q) ? gap_q + 15'h0001 : gap_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q      <= CNT_RESET;
            lost_q     <= 1'b0;
            bus_seen_q <= 1'b0;
        end else begin
            gap_q      <= gap_d;
            if (gap_full && !frame_valid)
                lost_q <= 1'b1;                          // see RULE_01
            else if (frame_valid)
                lost_q <= 1'b0;
            if (frame_valid)
                bus_seen_q <= 1'b1;
        end
    end

    // ==========================================
    // dynamic identifier table, one slot per pointer
    logic [5:0] dynid_q [NUM_PTR];
    logic [NUM_PTR-1:0] hit_vec;
    // pointers whose identifiers carry the slave address in bits 2:0
    localparam logic [NUM_PTR-1:0] ADDR_PTRS = 10'h21c;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    dynid_q[gi] <= DYNID_RESET;
                else if (dynid_we && dynid_ptr == 4'(gi))
                    dynid_q[gi] <= dynid_value;
            end
            // see RULE_19
            assign hit_vec[gi] = ADDR_PTRS[gi] ?
                (frame_id[5:3] == dynid_q[gi][5:3] &&
                 frame_id[2:0] == slave_address) :
                (frame_id == dynid_q[gi]);
        end
    endgenerate

    // lowest matching pointer wins; gp frames are slots 0 and 1
    logic [3:0] ptr_sel;
    always_comb begin
        ptr_sel = PTR_GP2;
        for (int i = NUM_PTR - 1; i >= 0; i--) begin
            if (hit_vec[i])
                ptr_sel = 4'(i);                         // see RULE_18
        end
    end
    wire logic any_hit = |hit_vec;                       // see RULE_20

    // ==========================================
    // application command decode
    wire logic cmd_known =
        cmd_code == CMD_READ_POS     || cmd_code == CMD_FULL_STATUS ||
        cmd_code == CMD_OTP_READ     || cmd_code == CMD_SHORT_STATUS ||
        cmd_code == CMD_SAFE_MOVE    || cmd_code == CMD_IMM_HALT ||
        cmd_code == CMD_POS_RESET    || cmd_code == CMD_DEC_HALT ||
        cmd_code == CMD_DYNID_ASSIGN;                    // see RULE_21
    // an unknown code is passed on as all ones so downstream ignores it
    wire logic [6:0] cmd_d = cmd_known ? cmd_code : 7'h7f;
    wire logic safe_cmd = cmd_valid && cmd_code == CMD_SAFE_MOVE;
    wire logic reset_cmd = cmd_valid && cmd_code == CMD_POS_RESET;

    // ==========================================
    // safe target ram copy and referencing
    llfs_state_e st_q;
    llfs_state_e st_d;
    wire logic   seq_ref_done = (st_q == LLFS_REF_WAIT) && stall_reached;
    logic [10:0] safe_q;
    logic        ref_q;
    logic        otp_mot_q;
    wire logic   reg_safe_we = reg_we && reg_addr == 4'h0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            safe_q <= SAFE_RESET;
            ref_q  <= 1'b0;
        end else begin
            if (safe_target_we)
                safe_q <= safe_target_wdata;             // see RULE_09
            else if (reg_safe_we)
                safe_q <= reg_wdata[10:0];               // see RULE_12
            if (referenced_set || reset_cmd || seq_ref_done)
                ref_q <= 1'b1;
        end
    end

    // ==========================================
    // fail-safe sequencer
    logic        startup_q;
    wire logic   trigger = lost_q ||                     // see RULE_13
                           hardwired_address_pin_float;
    wire logic   has_target = safe_q != SAFE_NONE;
    wire logic   want_ref = otp.failsafe_motion &&
                            (startup_q || !ref_q);       // see RULE_03
    wire logic   may_sleep = otp.sleep_enable &&         // see RULE_02
                             !(hardwired_address_pin_float && !lost_q);

    always_comb begin
        st_d = st_q;
        case (st_q)
            LLFS_IDLE: begin
                if (trigger || safe_cmd)
                    st_d = LLFS_DECIDE;                  // see RULE_04
            end
            LLFS_DECIDE: begin
                if (want_ref)
                    st_d = LLFS_REF_RUN;                 // see RULE_06
                else if (has_target)
                    st_d = LLFS_SAFE_MOVE;               // see RULE_05
                else
                    st_d = LLFS_PARK;
            end
            LLFS_REF_RUN:  st_d = LLFS_REF_WAIT;
            LLFS_REF_WAIT: begin
                if (stall_reached)
                    st_d = startup_q ? (has_target ? LLFS_SAFE_MOVE
                                                   : LLFS_PARK) // see RULE_17
                                     : LLFS_CONFIRM;     // see RULE_07
            end
            LLFS_CONFIRM: st_d = LLFS_CONFIRM_WAIT;
            LLFS_CONFIRM_WAIT: begin
                if (move_done)
                    st_d = has_target ? LLFS_SAFE_MOVE   // see RULE_08
                                      : LLFS_PARK;
            end
            LLFS_SAFE_MOVE: st_d = LLFS_SAFE_WAIT;
            LLFS_SAFE_WAIT: begin
                if (move_done)
                    st_d = LLFS_PARK;
            end
            LLFS_PARK: begin
                if (frame_valid && !trigger)
                    st_d = LLFS_IDLE;
            end
            default: st_d = LLFS_IDLE;
        endcase
    end

    // motion request built from the next state
    llfs_move_s mv_d;
    always_comb begin
        mv_d = '0;
        case (st_d)
            LLFS_REF_RUN: begin
                mv_d.start         = 1'b1;
                mv_d.to_stall      = 1'b1;
                mv_d.use_otp_param = 1'b1;
                mv_d.negative      = ~otp.dir_invert;    // see RULE_15
                mv_d.target        = half_range;
            end
            LLFS_CONFIRM: begin
                mv_d.start         = 1'b1;
                mv_d.use_otp_param = 1'b1;
                mv_d.negative      = ~otp.dir_invert;
                mv_d.target        = CONFIRM_STEPS;
            end
            LLFS_SAFE_MOVE: begin
                mv_d.start         = 1'b1;
                mv_d.absolute      = 1'b1;               // see RULE_10
                mv_d.use_otp_param = startup_q;
                mv_d.negative      = safe_q[SAFE_DIR_BIT] ^
                                     otp.dir_invert;     // see RULE_16
                mv_d.target = {{(POS_W-SAFE_W){safe_q[SAFE_W-1]}}, safe_q};
            end
            default: mv_d = '0;
        endcase
    end

    // ==========================================
    // state and output registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q            <= LLFS_IDLE;
            startup_q       <= 1'b1;
            otp_mot_q       <= 1'b0;
            move            <= '0;
            position_clear  <= 1'b0;
            target_position <= POS_RESET;
            lost_link       <= 1'b0;
            stop_state      <= 1'b0;
            sleep_state     <= 1'b0;
            ptr_hit         <= 1'b0;
            command_pointer <= PTR_GP2;
            cmd_decoded     <= 7'h7f;
        end else begin
            st_q           <= st_d;
            otp_mot_q      <= otp.failsafe_motion;
            // power-on case ends once traffic was seen or the sequencer was parked (see RULE_14)
            if (bus_seen_q || (st_q == LLFS_PARK))
                startup_q  <= 1'b0;
            move           <= mv_d;
            position_clear <= seq_ref_done;              // see RULE_07
            if (st_d == LLFS_SAFE_MOVE)
                target_position <= mv_d.target;          // see RULE_10
            lost_link      <= lost_q;
            stop_state     <= (st_d == LLFS_PARK) && !may_sleep; // see RULE_11
            sleep_state    <= (st_d == LLFS_PARK) && may_sleep;
            ptr_hit        <= frame_valid && any_hit;
            if (frame_valid && any_hit)
                command_pointer <= ptr_sel;
            if (cmd_valid)
                cmd_decoded <= cmd_d;
        end
    end

    // ==========================================
    // register read port: 0 safe target, 1 status, 2 position
    logic [15:0] rd_d;
    always_comb begin
        case (reg_addr)
            4'h0:    rd_d = {5'h00, safe_q};
            4'h1:    rd_d = {7'h00, otp_mot_q, startup_q, ref_q,
                             sleep_state, stop_state, lost_q, 3'(st_q)};
            4'h2:    rd_d = current_position;
            default: rd_d = 16'h0000;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= reg_re ? rd_d : 16'h0000;
    end

endmodule
`default_nettype wire

/* verilog/llfs_pkg.sv */
`default_nettype none
package llfs_pkg;

    // ==========================================
    // frame timing
    localparam int unsigned LOST_FRAME_COUNT = 25000;
    localparam logic [14:0] CNT_RESET        = 15'h0000;

    // ==========================================
    // positions
    localparam int unsigned      POS_W       = 16;
    localparam int unsigned      SAFE_W      = 11;
    localparam logic [10:0]      SAFE_NONE   = 11'h400;
    localparam int unsigned      SAFE_DIR_BIT = 10;
    localparam logic [15:0]      CONFIRM_STEPS = 16'h000a;
    localparam logic [15:0]      POS_RESET   = 16'h0000;
    localparam logic [10:0]      SAFE_RESET  = 11'h400;

    // ==========================================
    // application command codes
    localparam logic [6:0] CMD_READ_POS     = 7'h00;
    localparam logic [6:0] CMD_FULL_STATUS  = 7'h01;
    localparam logic [6:0] CMD_OTP_READ     = 7'h02;
    localparam logic [6:0] CMD_SHORT_STATUS = 7'h03;
    localparam logic [6:0] CMD_SAFE_MOVE    = 7'h04;
    localparam logic [6:0] CMD_IMM_HALT     = 7'h05;
    localparam logic [6:0] CMD_POS_RESET    = 7'h06;
    localparam logic [6:0] CMD_DEC_HALT     = 7'h0f;
    localparam logic [6:0] CMD_DYNID_ASSIGN = 7'h11;

    // ==========================================
    // command pointers
    localparam logic [3:0] PTR_GP2        = 4'h0;
    localparam logic [3:0] PTR_GP4        = 4'h1;
    localparam logic [3:0] PTR_READ_POS   = 4'h2;
    localparam logic [3:0] PTR_SHORT_STAT = 4'h3;
    localparam logic [3:0] PTR_MOVE16     = 4'h4;
    localparam logic [3:0] PTR_COMPACT1   = 4'h5;
    localparam logic [3:0] PTR_COMPACT2   = 4'h6;
    localparam logic [3:0] PTR_COMPACT4   = 4'h7;
    localparam logic [3:0] PTR_PREPARE    = 4'h8;
    localparam logic [3:0] PTR_MOVE_PARAM = 4'h9;
    localparam int unsigned NUM_PTR       = 10;
    localparam logic [5:0] DYNID_RESET    = 6'h3f;

    // ==========================================
    // sequencer states
    typedef enum logic [3:0] {
        LLFS_IDLE,
        LLFS_DECIDE,
        LLFS_REF_RUN,
        LLFS_REF_WAIT,
        LLFS_CONFIRM,
        LLFS_CONFIRM_WAIT,
        LLFS_SAFE_MOVE,
        LLFS_SAFE_WAIT,
        LLFS_PARK
    } llfs_state_e;

    // motion request carried to the position controller
    typedef struct packed {
        logic        start;
        logic        absolute;
        logic        to_stall;
        logic        use_otp_param;
        logic        negative;
        logic [15:0] target;
    } llfs_move_s;

    // one-time-programmable settings
    typedef struct packed {
        logic sleep_enable;
        logic failsafe_motion;
        logic dir_invert;
    } llfs_otp_s;

endpackage
`default_nettype wire

/* verification/llfs_sequencer_assertions.sv */
`default_nettype none
module llfs_sequencer_chk
    import llfs_pkg::*;
#(
    parameter int unsigned LOST_FRAMES = LOST_FRAME_COUNT
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // inputs watched
    input wire llfs_otp_s   otp,
    input wire logic        frame_tick,
    input wire logic        frame_valid,
    input wire logic        cmd_valid,
    input wire logic [6:0]  cmd_code,
    input wire logic        stall_reached,
    input wire logic [15:0] half_range,
    // outputs watched
    input wire logic        ptr_hit,
    input wire logic [6:0]  cmd_decoded,
    input wire llfs_move_s  move,
    input wire logic        position_clear,
    input wire logic        lost_link,
    input wire logic        stop_state,
    input wire logic        sleep_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ==========================================
    // gap count saturates so it never wraps back under the limit
    logic [15:0] gap_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            gap_q <= 16'h0000;
        else if (frame_valid)
            gap_q <= 16'h0000;
        else if (frame_tick && gap_q != 16'hffff)
            gap_q <= gap_q + 16'h0001;
    end

    // ==========================================
    // checks
    chk_lost_gap: assert property (
        $rose(lost_link) |-> gap_q >= LOST_FRAMES)
        else $error("lost link too early");
    chk_gap_restart: assert property (
        frame_valid |-> ##2 !lost_link)
        else $error("lost link kept");
    chk_start_once: assert property (
        move.start |=> !move.start)
        else $error("start too long");
    chk_clear_stall: assert property (
        stall_reached |=> position_clear)
        else $error("no position clear");
    chk_ref_dir: assert property (move.start && move.to_stall |->
        move.negative == !otp.dir_invert && move.target == half_range
        && move.use_otp_param)
        else $error("reference run fields wrong");
    chk_safe_dir: assert property (
        move.start && move.absolute |->
        move.negative == (move.target[10] ^ otp.dir_invert))
        else $error("safe move direction wrong");
    chk_safe_width: assert property (
        move.start && move.absolute |->
        move.target[15:11] == {5{move.target[10]}})
        else $error("safe target width");
    chk_park_one: assert property (
        !(stop_state && sleep_state))
        else $error("stop and sleep both set");
    chk_sleep_gate: assert property (
        sleep_state |-> otp.sleep_enable)
        else $error("sleep not enabled");
    chk_ptr_frame: assert property (
        ptr_hit |-> $past(frame_valid))
        else $error("pointer hit without frame");
    chk_cmd_code: assert property (cmd_valid |=> cmd_decoded ==
        (($past(cmd_code) inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
        7'h06, 7'h0f, 7'h11}) ? $past(cmd_code) : 7'h7f))
        else $error("command decode wrong");
endmodule

bind llfs_sequencer llfs_sequencer_chk #(.LOST_FRAMES(LOST_FRAMES)) i_chk (
    .clk, .rstn, .otp, .frame_tick, .frame_valid, .cmd_valid, .cmd_code,
    .stall_reached, .half_range, .ptr_hit, .cmd_decoded, .move,
    .position_clear, .lost_link, .stop_state, .sleep_state);
`default_nettype wire

/* verification/llfs_motion_model.sv */
`default_nettype none
module llfs_motion_model
    import llfs_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // move requests and pacing
    input  wire llfs_move_s move,
    input  wire logic       slow,
    // feedback
    output logic            move_done,
    output logic            stall_reached,
    output logic [15:0]     current_position
);
    logic [3:0]  wait_q;
    logic        stall_q;
    logic [15:0] tgt_q;

    // ==========================================
    // one answer per request, after a short or a long run
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 4'h0;
            stall_q <= 1'h0;
            tgt_q <= 16'h0000;
            move_done <= 1'h0;
            stall_reached <= 1'h0;
            current_position <= 16'h0000;
        end else begin
            move_done <= 1'h0;
            stall_reached <= 1'h0;
            if (move.start) begin
                wait_q <= slow ? 4'h9 : 4'h1;
                stall_q <= move.to_stall;
                tgt_q <= move.target;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
                if (wait_q == 4'h1) begin
                    move_done <= !stall_q;
                    stall_reached <= stall_q;
                    current_position <= stall_q ? 16'h0000 : tgt_q;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verification/llfs_sequencer_test.sv */
`default_nettype none
module llfs_sequencer_test
    import llfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk, rstn, slow, hardwired_address_pin_float;
    llfs_otp_s         otp;
    llfs_move_s        move;
    logic [2:0]        slave_address;
    logic              frame_tick, frame_valid, cmd_valid, dynid_we;
    logic [5:0]        frame_id, dynid_value;
    logic [6:0]        cmd_code, cmd_decoded;
    logic [3:0]        dynid_ptr, reg_addr, command_pointer;
    logic              move_done, stall_reached, reg_we, reg_re, ptr_hit;
    logic [15:0]       half_range, current_position, reg_wdata, reg_rdata;
    logic              position_clear, lost_link, stop_state, sleep_state;
    logic [15:0]       target_position;
    logic [31:0]       lfsr_q;
    logic [39:0]       me;
    logic              re_d, cmd_d;
    int                n_fail, num_checks, n_clr;
    logic [15:0]       rq[$];
    logic [6:0]        cq[$];
    logic [3:0]        pq[$];
    logic [39:0]       mq[$];
    logic [3:0]        dp[5] = '{4'h8, 4'h2, 4'h0, 4'h1, 4'h4};
    logic [5:0]        dv[5] = '{6'h1a, 6'h20, 6'h18, 6'h28, 6'h10};
    logic [6:0]        cc[10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h05, 7'h06,
                                  7'h0f, 7'h11, 7'h17, 7'h04};

    llfs_sequencer #(.LOST_FRAMES(8)) i_dut (.clk, .rstn, .otp,
        .hardwired_address_pin_float, .slave_address, .frame_tick,
        .frame_valid, .frame_id, .cmd_valid, .cmd_code, .dynid_we, .dynid_ptr,
        .dynid_value, .safe_target_we(1'h0), .safe_target_wdata(11'h000),
        .referenced_set(1'h0), .move_done, .stall_reached, .half_range,
        .current_position, .reg_addr, .reg_wdata, .reg_we, .reg_re,
        .reg_rdata, .ptr_hit, .command_pointer, .cmd_decoded, .move,
        .position_clear, .target_position, .lost_link, .stop_state,
        .sleep_state);
    llfs_motion_model i_motion (.clk, .rstn, .move, .slow, .move_done,
        .stall_reached, .current_position);

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset();
        rstn <= 1'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
    endtask
    task automatic frame(input logic [5:0] id);
        @(posedge clk);
        frame_valid <= 1'h1;
        frame_id <= id;
        @(posedge clk);
        frame_valid <= 1'h0;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            frame_tick <= 1'h1;
            @(posedge clk);
            frame_tick <= 1'h0;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_we, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge clk);
        reg_we <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        rq.push_back(e);
        @(posedge clk);
        {reg_re, reg_addr} <= {1'h1, a};
        @(posedge clk);
        reg_re <= 1'h0;
    endtask
    task automatic exp_move(input logic [19:0] m, input logic [19:0] v);
        mq.push_back({m, v & m});
    endtask
    // long enough for the slow partner to finish a three-move sequence
    task automatic settle();
        for (int i = 0; i < 80 && !(stop_state || sleep_state); i++)
            @(posedge clk);
        @(posedge clk);
    endtask

    // ==========================================
    // clock, watchdog and result monitor
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    always @(posedge clk) begin
        if (re_d)
            chk(rq.size() ? rq.pop_front() : '1, reg_rdata);
        if (cmd_d)
            chk(cq.size() ? cq.pop_front() : '1, cmd_decoded);
        if (ptr_hit)
            chk(pq.size() ? pq.pop_front() : '1,
                command_pointer);
        if (move.start) begin
            me = mq.size() ? mq.pop_front() : {20'h00000, 20'h00001};
            chk(me[19:0], move[19:0] & me[39:20]);
        end
        if (position_clear)
            n_clr++;
        re_d <= reg_re;
        cmd_d <= cmd_valid;
    end

    // ==========================================
    // main sequence
    initial begin
        {rstn, slow, hardwired_address_pin_float, frame_tick, frame_valid} = 0;
        {cmd_valid, dynid_we, reg_we, reg_re, re_d, cmd_d} = 0;
        {frame_id, cmd_code, dynid_ptr, dynid_value, reg_addr, reg_wdata} = 0;
        otp = '{1'h0, 1'h1, 1'h0};
        lfsr_q = lfsr_next(32'hb9f26f9c);
        half_range = lfsr_q[15:0];
        slave_address = lfsr_q[18:16];
        do_reset();
        rd(4'h0, 16'h0400);
        rd(4'hf, 16'h0000);
        wr(4'h0, 16'hfabc);
        rd(4'h0, 16'h02bc);
        exp_move(20'h7ffff, {4'b0111, half_range});
        exp_move(20'hfffff, {4'b1010, 16'h02bc});
        ticks(8);
        settle();
        chk(1, lost_link);
        chk(1, stop_state);
        chk(1, n_clr);
        chk(16'h02bc, target_position);
        rd(4'h2, 16'h02bc);
        $display("test startup reference done");
        slow <= 1'h1;
        otp.dir_invert <= 1'h1;
        frame(6'h3c);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            {dynid_we, dynid_ptr, dynid_value} <= {1'h1, dp[i], dv[i]};
            @(posedge clk);
            dynid_we <= 1'h0;
        end
        for (int i = 0; i < 5; i++) begin
            pq.push_back(dp[i]);
            frame((dp[i] == 4'h2 || dp[i] == 4'h4) ?
                {dv[i][5:3], slave_address} : dv[i]);
        end
        frame({3'h4, slave_address ^ 3'h1});
        exp_move(20'hdffff, {4'b1001, 16'h02bc});
        for (int i = 0; i < 10; i++) begin
            cq.push_back(cc[i] == 7'h17 ? 7'h7f : cc[i]);
            @(posedge clk);
            {cmd_valid, cmd_code} <= {1'h1, cc[i]};
            @(posedge clk);
            cmd_valid <= 1'h0;
        end
        settle();
        chk(1, stop_state);
        $display("test decode and command move done");
        frame(6'h3c);
        wr(4'h0, 16'h0500);
        otp.sleep_enable <= 1'h1;
        exp_move(20'hdffff, {4'b1000, 16'hfd00});
        hardwired_address_pin_float <= 1'h1;
        settle();
        chk(0, sleep_state);
        chk(1, stop_state);
        hardwired_address_pin_float <= 1'h0;
        $display("test floating address done");
        do_reset();
        {n_clr, slow} = 0;
        otp <= '{1'h1, 1'h1, 1'h1};
        lfsr_q = lfsr_next(lfsr_q);
        half_range <= lfsr_q[15:0];
        frame(6'h3c);
        ticks(7);
        frame(6'h3c);
        ticks(7);
        chk(0, lost_link);
        exp_move(20'h7ffff, {4'b0110, half_range});
        exp_move(20'h4ffff, {4'b0000, 16'h000a});
        ticks(1);
        settle();
        chk(1, sleep_state);
        chk(1, n_clr);
        chk(0, mq.size());
        $display("test operation reference done");
        do_reset();
        otp <= '{1'h0, 1'h0, 1'h0};
        wr(4'h0, 16'h0010);
        exp_move(20'hdffff, {4'b1000, 16'h0010});
        ticks(8);
        settle();
        chk(1, stop_state);
        chk(0, mq.size());
        $display("test startup direct move done");
        report_and_stop();
    end
endmodule
`default_nettype wire
